// *** rtl/gpio_mux_cfg.svh ***
`ifndef GPIO_MUX_CFG_SVH
`define GPIO_MUX_CFG_SVH

`define OFS_PIN_LEVEL_STATUS    8'h0e
`define OFS_PIN_INPUT_ENABLES   8'h0f
`define OFS_PIN0_OUTPUT_CONTROL 8'h10
`define OFS_RX_PORT_CONTROL     8'h0c

`define RST_PIN_LEVEL_STATUS    8'h00
`define RST_PIN_INPUT_ENABLES   8'hff
`define RST_PIN0_OUTPUT_CONTROL 8'h00
`define RST_RX_PORT_CONTROL     4'hf

`define POS_DRIVE_ENABLE        0
`define POS_DRIVE_VALUE         1
`define POS_SOURCE_LO           2
`define POS_SOURCE_HI           4
`define POS_SIGNAL_LO           5
`define POS_SIGNAL_HI           7

`endif

// *** rtl/gpio_mux_pkg.sv ***
package gpio_mux_pkg;

    typedef enum logic [2:0] {
        SRC_RX0    = 3'h0,
        SRC_RX1    = 3'h1,
        SRC_RX2    = 3'h2,
        SRC_RX3    = 3'h3,
        SRC_DEVICE = 3'h4,
        SRC_RSVD5  = 3'h5,
        SRC_CSI_TX = 3'h6,
        SRC_RSVD7  = 3'h7
    } source_t;

    // status of one receiver port
    typedef struct packed {
        logic [3:0] remote_pins;
        logic       lock;
        logic       pass;
        logic       frame_valid;
        logic       line_valid;
    } rx_status_t;

    // status of the csi-2 transmit port
    typedef struct packed {
        logic pass_and;
        logic pass_or;
        logic frame_active;
        logic line_active;
        logic synchronized;
        logic interrupt;
    } tx_status_t;

endpackage : gpio_mux_pkg

// *** rtl/gpio_status_input_output_mux.sv ***
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "gpio_mux_cfg.svh"
module gpio_status_input_output_mux
    import gpio_mux_pkg::*;
(
    input  wire logic           sys_clk_i,
    input  wire logic           rst_i,
    input  wire logic [7:0]     addr_i,
    input  wire logic [7:0]     wdata_i,
    input  wire logic           wr_i,
    input  wire logic           rd_i,
    output logic      [7:0]     rdata_o,
    input  wire logic [7:0]     pin_level_i,
    output logic                pin0_out_o,
    output logic                pin0_oe_o,
    input  wire rx_status_t [3:0] rx_status_i,
    input  wire tx_status_t     tx_status_i,
    input  wire logic           frame_sync_pulse_i,
    output logic      [3:0]     receiver_port_enable_o
);

    // ******************************************************
    // registers
    // ******************************************************
    logic [7:0] pin_level_bits;
    logic [7:0] pin_input_enables;
    logic [7:0] pin0_output_control;
    logic [3:0] receiver_port_enable;

    logic       pin0_drive_enable;
    logic       pin0_drive_value;
    source_t    pin0_source_select;
    logic [2:0] pin0_signal_select;

    assign pin0_drive_enable  = pin0_output_control[`POS_DRIVE_ENABLE];
    assign pin0_drive_value   = pin0_output_control[`POS_DRIVE_VALUE];
    assign pin0_source_select = source_t'(pin0_output_control[`POS_SOURCE_HI:`POS_SOURCE_LO]);
    assign pin0_signal_select = pin0_output_control[`POS_SIGNAL_HI:`POS_SIGNAL_LO];

    // ******************************************************
    // address decode
    // ******************************************************
    logic       hit_status;
    logic       hit_inputs;
    logic       hit_control;
    logic       hit_ports;
    logic       write_inputs;
    logic       write_control;
    logic       write_ports;
    logic       read_status;
    logic       read_inputs;
    logic       read_control;
    logic       read_ports;

    // exact decode: an alias would let a stray write reach the pin controls
    assign hit_status    = (addr_i == `OFS_PIN_LEVEL_STATUS);
    assign hit_inputs    = (addr_i == `OFS_PIN_INPUT_ENABLES);
    assign hit_control   = (addr_i == `OFS_PIN0_OUTPUT_CONTROL);
    assign hit_ports     = (addr_i == `OFS_RX_PORT_CONTROL);
    // status gets no write strobe, which keeps it read-only
    assign write_inputs  = wr_i & hit_inputs;
    assign write_control = wr_i & hit_control;
    assign write_ports   = wr_i & hit_ports;
    assign read_status   = rd_i & hit_status;
    assign read_inputs   = rd_i & hit_inputs;
    assign read_control  = rd_i & hit_control;
    assign read_ports    = rd_i & hit_ports;

    // ******************************************************
    // register storage
    // ******************************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_input_enables <= `RST_PIN_INPUT_ENABLES;
        end else if (write_inputs) begin
            pin_input_enables <= wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin0_output_control <= `RST_PIN0_OUTPUT_CONTROL;
        end else if (write_control) begin
            pin0_output_control <= wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            receiver_port_enable <= `RST_RX_PORT_CONTROL;
        end else if (write_ports) begin
            receiver_port_enable <= wdata_i[3:0];
        end
    end

    assign receiver_port_enable_o = receiver_port_enable;

    // ******************************************************
    // pin sampling
    // ******************************************************
    // one cycle sample, so status lags the pins by one clock
    logic [7:0] gated_level;

    generate
        for (genvar i = 0; i < 8; i++) begin : g_sample
            // a disabled input reads 0 instead of following the pin
            assign gated_level[i] = pin_level_i[i] & pin_input_enables[i];

            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    pin_level_bits[i] <= 1'b0;
                end else begin
                    pin_level_bits[i] <= gated_level[i];
                end
            end
        end
    endgenerate

    // ******************************************************
    // read port
    // ******************************************************
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (read_status) begin
            next_rdata = pin_level_bits;
        end else if (read_inputs) begin
            next_rdata = pin_input_enables;
        end else if (read_control) begin
            next_rdata = pin0_output_control;
        end else if (read_ports) begin
            next_rdata = {4'h0, receiver_port_enable};
        end else begin
            next_rdata = 8'h00;
        end
    end

    // registered: read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ******************************************************
    // combined receiver status
    // ******************************************************
    logic [3:0] lock_gated;
    logic [3:0] pass_gated;
    logic       lock_any;
    logic       pass_all;

    // disabled ports neither raise lock nor veto pass
    generate
        for (genvar p = 0; p < 4; p++) begin : g_port_gate
            assign lock_gated[p] = rx_status_i[p].lock & receiver_port_enable[p];
            assign pass_gated[p] = rx_status_i[p].pass | ~receiver_port_enable[p];
        end
    endgenerate

    // with no port enabled, lock reads 0 and pass reads 1
    assign lock_any = |lock_gated;
    assign pass_all = &pass_gated;

    // ******************************************************
    // signal pickers, one per source kind: receiver (shared by all four ports), device, transmit
    // ******************************************************
    logic [1:0] rx_port;
    rx_status_t rx_sel;
    logic       rx_pick;
    logic       dev_pick;
    logic       tx_pick;

    assign rx_port = pin0_source_select[1:0];
    assign rx_sel  = rx_status_i[rx_port];

    always_comb begin
        rx_pick = 1'b0;
        case (pin0_signal_select)
            3'h0: begin
                rx_pick = rx_sel.remote_pins[0];
            end
            3'h1: begin
                rx_pick = rx_sel.remote_pins[1];
            end
            3'h2: begin
                rx_pick = rx_sel.remote_pins[2];
            end
            3'h3: begin
                rx_pick = rx_sel.remote_pins[3];
            end
            3'h4: begin
                rx_pick = rx_sel.lock;
            end
            3'h5: begin
                rx_pick = rx_sel.pass;
            end
            3'h6: begin
                rx_pick = rx_sel.frame_valid;
            end
            default: begin
                rx_pick = rx_sel.line_valid;
            end
        endcase
    end

    always_comb begin
        dev_pick = 1'b0;
        case (pin0_signal_select)
            3'h0: begin
                dev_pick = pin0_drive_value;
            end
            3'h1: begin
                dev_pick = lock_any;
            end
            3'h2, 3'h3: begin
                dev_pick = pass_all;
            end
            3'h4: begin
                dev_pick = frame_sync_pulse_i;
            end
            default: begin
                dev_pick = 1'b0;
            end
        endcase
    end

    always_comb begin
        tx_pick = 1'b0;
        case (pin0_signal_select)
            3'h0: begin
                tx_pick = tx_status_i.pass_and;
            end
            3'h1: begin
                tx_pick = tx_status_i.pass_or;
            end
            3'h2: begin
                tx_pick = tx_status_i.frame_active;
            end
            3'h3: begin
                tx_pick = tx_status_i.line_active;
            end
            3'h4: begin
                tx_pick = tx_status_i.synchronized;
            end
            3'h5: begin
                tx_pick = tx_status_i.interrupt;
            end
            default: begin
                tx_pick = 1'b0;
            end
        endcase
    end

    // ******************************************************
    // source mux
    // ******************************************************
    logic       next_pin0_out;

    always_comb begin
        next_pin0_out = 1'b0;
        case (pin0_source_select)
            SRC_RX0, SRC_RX1, SRC_RX2, SRC_RX3: begin
                next_pin0_out = rx_pick;
            end
            SRC_DEVICE: begin
                next_pin0_out = dev_pick;
            end
            SRC_CSI_TX: begin
                next_pin0_out = tx_pick;
            end
            // reserved sources drive low rather than echo a neighbour
            default: begin
                next_pin0_out = 1'b0;
            end
        endcase
    end

    // ******************************************************
    // pin drive
    // ******************************************************
    // registered so the pin never glitches while the mux settles
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin0_out_o <= 1'b0;
        end else begin
            pin0_out_o <= next_pin0_out & pin0_drive_enable;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin0_oe_o <= 1'b0;
        end else begin
            pin0_oe_o <= pin0_drive_enable;
        end
    end

endmodule : gpio_status_input_output_mux

// *** tb/pin_partner.sv ***
`timescale 1ns/1ps
module pin_partner (
    input  wire logic [7:0] level_i,
    input  wire logic       pin0_out_i,
    input  wire logic       pin0_oe_i,
    output logic      [7:0] wire_o
);
    // the far side only drives pin 0 while the device leaves it undriven
    assign wire_o = {level_i[7:1], pin0_oe_i ? pin0_out_i : level_i[0]};
endmodule : pin_partner

// *** tb/gpio_mux_props.sv ***
`timescale 1ns/1ps
module gpio_mux_props (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] pin_level_i,
    input wire logic       pin0_out_o,
    input wire logic       pin0_oe_o,
    input wire logic [3:0] receiver_port_enable_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence ctl_wr;
        wr_i && addr_i == 8'h10;
    endsequence
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero");
    a_status_pins: assert property (rd_i && addr_i == 8'h0e |=>
        (rdata_o & ~$past(pin_level_i, 2)) == 8'h00) else $error("status without level");
    sequence ctl_wr_alone;
        ctl_wr ##1 !ctl_wr;
    endsequence
    a_oe_write: assert property (ctl_wr_alone |=> pin0_oe_o == $past(wdata_i[0], 2))
        else $error("drive enable wrong");
    a_off_low: assert property (!pin0_oe_o |-> !pin0_out_o)
        else $error("data while undriven");
    a_dev_value: assert property (ctl_wr ##0 ((wdata_i & 8'hfd) == 8'h11) ##1 !ctl_wr |=>
        pin0_out_o == $past(wdata_i[1], 2)) else $error("drive value wrong");
    a_rsvd_src: assert property (ctl_wr ##0 (wdata_i[4] && wdata_i[2]) ##1 !ctl_wr |=>
        !pin0_out_o) else $error("reserved source drives high");
    a_en_write: assert property (wr_i && addr_i == 8'h0c |=>
        receiver_port_enable_o == $past(wdata_i[3:0])) else $error("port enables wrong");
    a_en_read: assert property (rd_i && addr_i == 8'h0c |=>
        rdata_o == {4'h0, $past(receiver_port_enable_o)}) else $error("port read wrong");
endmodule : gpio_mux_props
bind gpio_status_input_output_mux gpio_mux_props chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_level_i(pin_level_i), .pin0_out_o(pin0_out_o), .pin0_oe_o(pin0_oe_o),
    .receiver_port_enable_o(receiver_port_enable_o));

// *** tb/gpio_status_input_output_mux_bench.sv ***
`timescale 1ns/1ps
module gpio_status_input_output_mux_bench
    import gpio_mux_pkg::*;
;
    logic             sys_clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic [7:0]       addr_i = 8'h00, wdata_i = 8'h00, level = 8'h00, rdata_o, pins;
    logic             wr_i = 1'b0, rd_i = 1'b0, sync = 1'b0, pin0_out_o, pin0_oe_o;
    rx_status_t [3:0] rx = '0;
    tx_status_t       tx = '0;
    logic [3:0]       port_en;
    int               fails = 0, n_compared = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    gpio_status_input_output_mux DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_level_i(pins),
        .pin0_out_o(pin0_out_o), .pin0_oe_o(pin0_oe_o), .rx_status_i(rx), .tx_status_i(tx),
        .frame_sync_pulse_i(sync), .receiver_port_enable_o(port_en));
    pin_partner far (.level_i(level), .pin0_out_i(pin0_out_o), .pin0_oe_i(pin0_oe_o),
        .wire_o(pins));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 check(what, rdata_o, exp);
        @(posedge sys_clk_i);
    endtask : rd_chk
    // control byte is {select, source, value, enable}; pin output lags one edge
    task automatic pin_chk(input logic [7:0] ctl, input logic exp);
        wr(8'h10, ctl);
        @(posedge sys_clk_i);
        #1 check("pin0", {6'h0, pin0_oe_o, pin0_out_o}, {6'h0, ctl[0], exp});
        @(posedge sys_clk_i);
    endtask : pin_chk
    task automatic t_reset;
        rd_chk(8'h0f, 8'hff, "inputs");
        rd_chk(8'h10, 8'h00, "control");
        rd_chk(8'h0c, 8'h0f, "ports");
        rd_chk(8'h20, 8'h00, "unmapped");
        $display("reset test done");
    endtask : t_reset
    task automatic t_status;
        level <= 8'ha5;
        rd_chk(8'h0e, 8'ha5, "levels");
        wr(8'h0f, 8'h0f);
        rd_chk(8'h0e, 8'h05, "masked");
        wr(8'h0f, 8'hff);
        level <= 8'h00;
        pin_chk(8'h13, 1'b1);
        rd_chk(8'h0e, 8'h01, "pin0 wire");
        pin_chk(8'h12, 1'b0);
        $display("status test done");
    endtask : t_status
    task automatic t_rx;
        logic [31:0] p;
        logic [7:0]  b;
        for (int i = 0; i < 64; i++) begin
            p = i[5] ? 32'h96e1_5ac3 : 32'h691e_a53c;
            rx <= p;
            b = p[8 * i[4:3] +: 8];
            pin_chk({i[2:0], 1'b0, i[4:3], 2'b01}, b[i[2] ? 3'd7 - i[2:0] : 3'd4 + i[1:0]]);
        end
        $display("receiver source test done");
    endtask : t_rx
    task automatic t_dev;
        rx <= 32'h040c_0004;
        tx <= '1;
        sync <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(8'h0c, m ? 8'h02 : 8'h0d);
            pin_chk(8'h31, m == 0);
            pin_chk(8'h51, m == 0);
            pin_chk(8'h71, m == 0);
        end
        pin_chk(8'h91, 1'b1);
        for (int s = 5; s < 8; s++) pin_chk({s[2:0], 5'h11}, 1'b0);
        pin_chk(8'h95, 1'b0);
        pin_chk(8'h9d, 1'b0);
        sync <= 1'b0;
        pin_chk(8'h91, 1'b0);
        $display("device source test done");
    endtask : t_dev
    task automatic t_tx;
        for (int s = 0; s < 8; s++) begin
            tx <= 6'h20 >> s;
            pin_chk({s[2:0], 5'h19}, s < 6);
            tx <= ~(6'h20 >> s);
            pin_chk({s[2:0], 5'h19}, 1'b0);
        end
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_chk(8'h10, 8'h00, "control");
        $display("transmit source test done");
    endtask : t_tx
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_status();
        t_rx();
        t_dev();
        t_tx();
        complete_run();
    end
    // tests need about 420 cycles; the 8000-cycle limit allows about 19 times that
    initial begin
        #200us;
        fails++;
        complete_run();
    end
endmodule : gpio_status_input_output_mux_bench
